// *** fsp_host_model.sv ***
// host model: sends command frames on the serial link
// assumes mode 0, link clock idle low, 80 ns link period
`timescale 1ns/1ns
`default_nettype none
module fsp_host_model
(
    // link outputs
    output var logic sclk,
    output var logic cs_n,
    output var logic mosi,
    // link inputs
    input  wire logic miso,
    input  wire logic miso_oe_n
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // msb first; reply bits gathered after the opcode
    task automatic frame(input logic [55:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        #7 cs_n = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++)
        begin
            mosi = word[55 - i];
            #40 sclk = 1'b1;
            if (i >= 8)
                rd = {rd[6:0], miso_oe_n ? 1'bx : miso};
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        // released line no longer shows the last bit
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

// *** fsp_pkg.sv ***
// constants and types for the status and write-protect block
// assumes a single-bit serial command link, mode 0, 4-byte addresses
package fsp_pkg;

    // ****************************************
    // status register layout
    // ****************************************
    typedef struct packed {
        logic       wr_disable;   // bit 7, nonvolatile
        logic       bp_hi;        // bit 6, block_protect_field[3]
        logic       bottom_sel;   // bit 5, nonvolatile
        logic [2:0] bp_lo;        // bits 4:2, block_protect_field[2:0]
        logic       wel;          // bit 1, volatile
        logic       busy;         // bit 0
    } fsp_status_t;

    localparam fsp_status_t STATUS_RESET = '0;

    // flag status bit positions
    localparam int FL_READY    = 7;
    localparam int FL_ERASE    = 5;
    localparam int FL_PROGRAM  = 4;
    localparam int FL_PROTECT  = 1;
    localparam int FL_ADDR4    = 0;
    localparam logic [7:0] FLAG_ERR_MASK = 8'h32;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_PROGRAM   = 8'h12;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_SUB4_ER   = 8'h21;
    localparam logic [7:0] OP_CLR_FLAG  = 8'h50;
    localparam logic [7:0] OP_SUB32_ER  = 8'h5C;
    localparam logic [7:0] OP_RD_FLAG   = 8'h70;
    localparam logic [7:0] OP_DIE_ER    = 8'hC4;
    localparam logic [7:0] OP_SECT_ER   = 8'hDC;

    // ****************************************
    // frame lengths in serial clocks
    // ****************************************
    localparam logic [5:0] LEN_CMD     = 6'd8;
    localparam logic [5:0] LEN_WRSR    = 6'd16;
    localparam logic [5:0] LEN_ERASE   = 6'd40;
    localparam logic [5:0] LEN_PROGRAM = 6'd48;
    localparam logic [5:0] CNT_CMD_END  = 6'd7;
    localparam logic [5:0] CNT_WRSR_END = 6'd15;
    localparam logic [5:0] CNT_ADDR_END = 6'd39;
    localparam logic [5:0] CNT_MAX      = 6'd63;

    // ****************************************
    // array geometry
    // ****************************************
    localparam int SECTOR_LSB  = 16;
    localparam int SUB32_LSB   = 15;
    localparam int SUB4_LSB    = 12;
    localparam int SECTOR_W    = 11;
    localparam logic [3:0]  BP_ALL      = 4'd12;
    localparam logic [11:0] SECTOR_CNT  = 12'h800;

    // ****************************************
    // operation timing, in core clocks
    // ****************************************
    localparam logic [15:0] T_WRSR_CYC  = 16'h0064;
    localparam logic [15:0] T_PROG_CYC  = 16'h00C8;
    localparam logic [15:0] T_ERASE_CYC = 16'h0190;

    typedef enum logic {ST_IDLE, ST_BUSY} fsp_state_t;

endpackage

// *** fsp_status_protect.sv ***
// status register, write-enable latch and write protection of a serial flash
// assumes: link runs on sclk (mode 0), core on clock; host obeys frame setup
`timescale 1ns/1ns
`default_nettype none
module fsp_status_protect
#(
    parameter logic [15:0] WRSR_CYCLES  = fsp_pkg::T_WRSR_CYC,
    parameter logic [15:0] PROG_CYCLES  = fsp_pkg::T_PROG_CYC,
    parameter logic [15:0] ERASE_CYCLES = fsp_pkg::T_ERASE_CYC
)
(
    // core clock and reset
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // serial link
    input  wire logic                 sclk,
    input  wire logic                 cs_n,
    input  wire logic                 mosi,
    output logic                      miso,
    output logic                      miso_oe_n,
    // write-protect pin
    input  wire logic                 wp_n,
    // observation
    output fsp_pkg::fsp_status_t      status_o,
    output logic [7:0]                flag_o,
    output logic                      hw_protected_o
);

    // ****************************************
    // link domain: command capture
    // ****************************************
    logic [5:0]  cnt_r, cnt_nxt;
    logic [7:0]  cmd_r, cmd_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [7:0]  wdat_r, wdat_nxt;
    logic [5:0]  len_r, len_nxt;
    logic        tog_r, tog_nxt;
    logic [7:0]  snap_sr_r, snap_fl_r;
    logic        miso_r;
    logic        rd_sel;
    logic        link_clr_n;
    always_comb
    begin
        cnt_nxt  = (cnt_r == fsp_pkg::CNT_MAX) ? cnt_r : cnt_r + 6'd1;
        len_nxt  = cnt_nxt;
        tog_nxt  = (cnt_r == 6'd0) ? ~tog_r : tog_r;
        sh_nxt   = {sh_r[30:0], mosi};
        cmd_nxt  = (cnt_r == fsp_pkg::CNT_CMD_END) ? sh_nxt[7:0] : cmd_r;
        wdat_nxt = (cnt_r == fsp_pkg::CNT_WRSR_END) ? sh_nxt[7:0] : wdat_r;
        addr_nxt = (cnt_r == fsp_pkg::CNT_ADDR_END) ? sh_nxt : addr_r;
    end
    // bit counter restarts with every frame and with reset; sclk is idle in reset
    assign link_clr_n = arst_n & ~cs_n;
    always_ff @(posedge sclk or negedge link_clr_n)
    begin
        if (!link_clr_n)
            cnt_r <= 6'd0;
        else
            cnt_r <= cnt_nxt;
    end
    // captured fields hold after the frame for the core to take
    always_ff @(posedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_r  <= 8'h00;
            sh_r   <= 32'h0000_0000;
            addr_r <= 32'h0000_0000;
            wdat_r <= 8'h00;
            len_r  <= 6'd0;
            tog_r  <= 1'b0;
        end
        else
        begin
            cmd_r  <= cmd_nxt;
            sh_r   <= sh_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            len_r  <= len_nxt;
            tog_r  <= tog_nxt;
        end
    end

    // read data leaves on the falling edge; snapshots are frozen in a frame
    assign rd_sel = (cmd_r == fsp_pkg::OP_RD_STATUS) || (cmd_r == fsp_pkg::OP_RD_FLAG);
    always_ff @(negedge sclk or negedge arst_n)
    begin
        if (!arst_n)
            miso_r <= 1'b0;
        else if (cmd_r == fsp_pkg::OP_RD_FLAG)
            miso_r <= snap_fl_r[~cnt_r[2:0]];
        else
            miso_r <= snap_sr_r[~cnt_r[2:0]];
    end
    assign miso      = miso_r;
    assign miso_oe_n = cs_n | ~rd_sel | (cnt_r < fsp_pkg::LEN_CMD);

    // ****************************************
    // core domain: pin synchronisers
    // ****************************************
    // bit 2 wp_n, bit 1 cs_n, bit 0 frame toggle
    logic [2:0] s1_r, s2_r, s3_r;
    logic [2:0] stab_r, stab_nxt;
    logic       cs_prev_r;
    assign stab_nxt = (s2_r & s3_r) | (stab_r & (s2_r ^ s3_r));
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r      <= 3'b110;
            s2_r      <= 3'b110;
            s3_r      <= 3'b110;
            stab_r    <= 3'b110;
            cs_prev_r <= 1'b1;
        end
        else
        begin
            s1_r      <= {wp_n, cs_n, tog_r};
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            stab_r    <= stab_nxt;
            cs_prev_r <= stab_r[1];
        end
    end

    // ****************************************
    // core domain: status and operations
    // ****************************************
    fsp_pkg::fsp_status_t sr_r, sr_nxt;
    fsp_pkg::fsp_state_t  st_r, st_nxt;
    logic [7:0]  fl_err_r, fl_err_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic        seen_r, seen_nxt;
    logic [7:0]  snap_sr_nxt, snap_fl_nxt;
    logic        frame_end;
    logic        hw_lock;
    logic [3:0]  bp;
    logic [fsp_pkg::SECTOR_W-1:0] sector;
    logic [14:0] sub4k;
    logic [11:0] sub32k;
    logic        locked;
    logic        is_erase;
    logic        is_prog;
    function automatic logic sector_locked(input logic [10:0] sec, input logic [3:0] bpf,
                                           input logic bot);
        logic [11:0] span;
        span = 12'h001 << (bpf - 4'd1);
        if (bpf == 4'd0)
            sector_locked = 1'b0;
        else if (bpf >= fsp_pkg::BP_ALL)
            sector_locked = 1'b1;
        else if (bot)
            sector_locked = ({1'b0, sec} < span);
        else
            sector_locked = ({1'b0, sec} >= (fsp_pkg::SECTOR_CNT - span));
    endfunction
    assign frame_end = stab_r[1] & ~cs_prev_r & (stab_r[0] != seen_r);
    assign hw_lock   = sr_r.wr_disable & ~stab_r[2];
    assign bp        = {sr_r.bp_hi, sr_r.bp_lo};
    assign sub4k     = addr_r[fsp_pkg::SUB4_LSB +: 15];
    assign sub32k    = addr_r[fsp_pkg::SUB32_LSB +: 12];
    assign sector    = (cmd_r == fsp_pkg::OP_SUB4_ER) ? sub4k[14:4] :
                       (cmd_r == fsp_pkg::OP_SUB32_ER) ? sub32k[11:1] :
                       addr_r[fsp_pkg::SECTOR_LSB +: 11];
    assign locked    = sector_locked(sector, bp, sr_r.bottom_sel);
    assign is_erase  = ((cmd_r == fsp_pkg::OP_SECT_ER) || (cmd_r == fsp_pkg::OP_SUB4_ER) ||
                        (cmd_r == fsp_pkg::OP_SUB32_ER)) && (len_r >= fsp_pkg::LEN_ERASE);
    assign is_prog   = (cmd_r == fsp_pkg::OP_PROGRAM) && (len_r >= fsp_pkg::LEN_PROGRAM);

    always_comb
    begin
        sr_nxt     = sr_r;
        st_nxt     = st_r;
        fl_err_nxt = fl_err_r;
        tmr_nxt    = tmr_r;
        seen_nxt   = frame_end ? stab_r[0] : seen_r;
        case (st_r)
            fsp_pkg::ST_IDLE:
            begin
                if (frame_end)
                begin
                    case (cmd_r)
                        fsp_pkg::OP_WR_EN:
                            sr_nxt.wel = 1'b1;
                        fsp_pkg::OP_WR_DIS:
                            sr_nxt.wel = 1'b0;
                        fsp_pkg::OP_CLR_FLAG:
                            fl_err_nxt = 8'h00;
                        fsp_pkg::OP_WR_STATUS:
                        begin
                            if (sr_r.wel && !hw_lock && len_r >= fsp_pkg::LEN_WRSR)
                            begin
                                sr_nxt.wr_disable = wdat_r[7];
                                sr_nxt.bp_hi      = wdat_r[6];
                                sr_nxt.bottom_sel = wdat_r[5];
                                sr_nxt.bp_lo      = wdat_r[4:2];
                                tmr_nxt           = WRSR_CYCLES;
                                st_nxt            = fsp_pkg::ST_BUSY;
                            end
                        end
                        fsp_pkg::OP_DIE_ER:
                        begin
                            if (sr_r.wel && bp != 4'd0)
                                fl_err_nxt[fsp_pkg::FL_ERASE] = 1'b1;
                            else if (sr_r.wel)
                            begin
                                tmr_nxt = ERASE_CYCLES;
                                st_nxt  = fsp_pkg::ST_BUSY;
                            end
                        end
                        default:
                        begin
                            if ((is_erase || is_prog) && sr_r.wel && locked)
                            begin
                                fl_err_nxt[fsp_pkg::FL_PROTECT] = 1'b1;
                                if (is_erase)
                                    fl_err_nxt[fsp_pkg::FL_ERASE] = 1'b1;
                                else
                                    fl_err_nxt[fsp_pkg::FL_PROGRAM] = 1'b1;
                            end
                            else if ((is_erase || is_prog) && sr_r.wel)
                            begin
                                tmr_nxt = is_erase ? ERASE_CYCLES : PROG_CYCLES;
                                st_nxt  = fsp_pkg::ST_BUSY;
                            end
                        end
                    endcase
                end
            end
            fsp_pkg::ST_BUSY:
            begin
                tmr_nxt = tmr_r - 16'h0001;
                if (tmr_r <= 16'h0001)
                begin
                    sr_nxt.wel = 1'b0;
                    st_nxt     = fsp_pkg::ST_IDLE;
                end
            end
            default:
                st_nxt = fsp_pkg::ST_IDLE;
        endcase
        sr_nxt.busy = (st_nxt == fsp_pkg::ST_BUSY);
        snap_sr_nxt = stab_r[1] ? sr_r : snap_sr_r;
        snap_fl_nxt = stab_r[1] ? flag_o : snap_fl_r;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sr_r      <= fsp_pkg::STATUS_RESET;
            st_r      <= fsp_pkg::ST_IDLE;
            fl_err_r  <= 8'h00;
            tmr_r     <= 16'h0000;
            seen_r    <= 1'b0;
            snap_sr_r <= 8'h00;
            snap_fl_r <= 8'h81;
        end
        else
        begin
            sr_r      <= sr_nxt;
            st_r      <= st_nxt;
            fl_err_r  <= fl_err_nxt;
            tmr_r     <= tmr_nxt;
            seen_r    <= seen_nxt;
            snap_sr_r <= snap_sr_nxt;
            snap_fl_r <= snap_fl_nxt;
        end
    end

    assign status_o       = sr_r;
    assign hw_protected_o = hw_lock;
    assign flag_o         = {~sr_r.busy, 1'b0, fl_err_r[5:4], 2'b00, fl_err_r[1], 1'b1};

endmodule
`default_nettype wire

// *** fsp_status_protect_checker.sv ***
// checker: port assertions for the status and write-protect block
// assumes bind into fsp_status_protect, core clock domain only
`timescale 1ns/1ns
`default_nettype none
module fsp_status_protect_checker
#(
    parameter logic [15:0] WRSR_CYCLES  = 16'h0064,
    parameter logic [15:0] PROG_CYCLES  = 16'h00C8,
    parameter logic [15:0] ERASE_CYCLES = 16'h0190
)
(
    // clock and reset
    input wire logic                 clock,
    input wire logic                 arst_n,
    // link and pin
    input wire logic                 sclk,
    input wire logic                 cs_n,
    input wire logic                 mosi,
    input wire logic                 miso,
    input wire logic                 miso_oe_n,
    input wire logic                 wp_n,
    // observation
    input wire fsp_pkg::fsp_status_t status_o,
    input wire logic [7:0]           flag_o,
    input wire logic                 hw_protected_o
);
    // ****************************************
    // helper logic
    // ****************************************
    logic [15:0] busy_len_r;
    logic [15:0] busy_len_nxt;
    logic [5:0]  nv_bits;
    assign nv_bits = {status_o.wr_disable, status_o.bp_hi, status_o.bottom_sel, status_o.bp_lo};
    // counts core clocks of one busy period
    always_comb busy_len_nxt = status_o.busy ? busy_len_r + 16'h0001 : 16'h0000;
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            busy_len_r <= 16'h0000;
        else
            busy_len_r <= busy_len_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence op_start_s;
        !status_o.busy ##1 status_o.busy;
    endsequence
    sequence op_end_s;
        status_o.busy ##1 !status_o.busy;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    busy_ready_a: assert property (
        status_o.busy == !flag_o[fsp_pkg::FL_READY]) else $error("busy and ready disagree");
    busy_len_a: assert property (
        op_end_s |-> busy_len_r == WRSR_CYCLES || busy_len_r == PROG_CYCLES
        || busy_len_r == ERASE_CYCLES) else $error("busy period of wrong length");
    start_wel_a: assert property (
        op_start_s |-> $past(status_o.wel)) else $error("operation began without latch");
    end_wel_a: assert property (
        op_end_s |-> ##[0:1] !status_o.wel) else $error("latch kept after operation");
    nv_change_a: assert property (
        !$stable(nv_bits) |-> $rose(status_o.busy)) else $error("status bits changed alone");
    hw_freeze_a: assert property (
        hw_protected_o ##1 hw_protected_o |-> $stable(nv_bits)) else $error("frozen bits moved");
    hw_release_a: assert property (
        $fell(hw_protected_o) |-> $past(wp_n, 3)) else $error("protection left with pin low");
    protect_flag_a: assert property (
        $rose(flag_o[fsp_pkg::FL_PROTECT]) |-> !status_o.busy && (flag_o[fsp_pkg::FL_ERASE]
        || flag_o[fsp_pkg::FL_PROGRAM])) else $error("protection error without op error");
    oe_frame_a: assert property (
        cs_n |-> miso_oe_n) else $error("output driven outside frame");
    reset_wel_a: assert property (
        !$past(arst_n) |-> !status_o.wel && !status_o.busy) else $error("latch set after reset");
endmodule
bind fsp_status_protect fsp_status_protect_checker
#(
    .WRSR_CYCLES (WRSR_CYCLES),
    .PROG_CYCLES (PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
)
chk
(
    .clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .wp_n(wp_n), .status_o(status_o), .flag_o(flag_o),
    .hw_protected_o(hw_protected_o)
);
`default_nettype wire

// *** fsp_status_protect_test.sv ***
// testbench: command sequences through the host model, checked against expectations
// assumes the host model and checker files are compiled first
`timescale 1ns/1ns
`default_nettype none
module fsp_status_protect_test;
    logic                 clock;
    logic                 arst_n;
    logic                 wp_n;
    logic                 sclk;
    logic                 cs_n;
    logic                 mosi;
    logic                 miso;
    logic                 miso_oe_n;
    fsp_pkg::fsp_status_t status_o;
    logic [7:0]           flag_o;
    logic                 hw_protected_o;
    logic [7:0]           rd;
    int                   failures;
    int                   total_checks;
    logic [7:0]           ers [3] = '{fsp_pkg::OP_SUB4_ER, fsp_pkg::OP_SUB32_ER, fsp_pkg::OP_SECT_ER};
    fsp_status_protect #(.WRSR_CYCLES(16'h0006), .PROG_CYCLES(16'h0008),
        .ERASE_CYCLES(16'h000A)) dut
    (
        .clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .wp_n(wp_n), .status_o(status_o), .flag_o(flag_o),
        .hw_protected_o(hw_protected_o)
    );
    fsp_host_model host
    (
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one frame, then a gap long enough for any operation; compares busy seen
    task automatic cmd(input logic [7:0] op, input logic [47:0] tail, input int nbits,
                       input logic exp_busy);
        logic bz;
        bz = 1'b0;
        host.frame({op, tail}, nbits, rd);
        repeat (40)
        begin
            @(negedge clock);
            if (status_o.busy === 1'b1)
                bz = 1'b1;
        end
        check({7'h00, bz}, {7'h00, exp_busy});
    endtask
    task automatic rd_stat(input logic [7:0] exp);
        cmd(fsp_pkg::OP_RD_STATUS, 48'h0, 16, 1'b0);
        check(rd, exp);
        check(status_o, exp);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        #500000;
        failures++;
        summarize();
    end
    initial
    begin
        failures = 0;
        total_checks = 0;
        arst_n = 1'b0;
        wp_n = 1'b1;
        repeat (5) @(negedge clock);
        arst_n = 1'b1;
        repeat (5) @(negedge clock);
        check(status_o, 8'h00);
        check(flag_o, 8'h81);
        rd_stat(8'h00);
        cmd(fsp_pkg::OP_WR_STATUS, {8'h3C, 40'h0}, 16, 1'b0);
        rd_stat(8'h00);
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        rd_stat(8'h02);
        cmd(fsp_pkg::OP_WR_DIS, 48'h0, 8, 1'b0);
        rd_stat(8'h00);
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_WR_STATUS, {8'h9C, 40'h0}, 16, 1'b1);
        rd_stat(8'h9C);
        wp_n = 1'b0;
        repeat (10) @(negedge clock);
        check({7'h00, hw_protected_o}, 8'h01);
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_WR_STATUS, {8'h00, 40'h0}, 16, 1'b0);
        rd_stat(8'h9E);
        wp_n = 1'b1;
        repeat (10) @(negedge clock);
        check({7'h00, hw_protected_o}, 8'h00);
        cmd(fsp_pkg::OP_WR_STATUS, {8'h04, 40'h0}, 16, 1'b1);
        rd_stat(8'h04);
        // top anchored: last sector refused, first accepted
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_SECT_ER, {32'h07FF_0000, 16'h0}, 40, 1'b0);
        check(flag_o, 8'hA3);
        rd_stat(8'h06);
        cmd(fsp_pkg::OP_CLR_FLAG, 48'h0, 8, 1'b0);
        check(flag_o, 8'h81);
        cmd(fsp_pkg::OP_SECT_ER, 48'h0, 40, 1'b1);
        rd_stat(8'h04);
        cmd(fsp_pkg::OP_SECT_ER, 48'h0, 40, 1'b0);
        // bottom anchored: every erase size in sector 0 refused
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_WR_STATUS, {8'h24, 40'h0}, 16, 1'b1);
        rd_stat(8'h24);
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        foreach (ers[k])
        begin
            cmd(ers[k], {32'h0000_8000, 16'h0}, 40, 1'b0);
            check(flag_o, 8'hA3);
            cmd(fsp_pkg::OP_CLR_FLAG, 48'h0, 8, 1'b0);
        end
        cmd(fsp_pkg::OP_PROGRAM, {32'h07FF_0000, 16'hA500}, 48, 1'b1);
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_PROGRAM, {32'h0000_1000, 16'hA500}, 48, 1'b0);
        check(flag_o, 8'h93);
        cmd(fsp_pkg::OP_CLR_FLAG, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_DIE_ER, 48'h0, 8, 1'b0);
        check(flag_o, 8'hA1);
        cmd(fsp_pkg::OP_CLR_FLAG, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_WR_STATUS, {8'h00, 40'h0}, 16, 1'b1);
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        cmd(fsp_pkg::OP_DIE_ER, 48'h0, 8, 1'b1);
        rd_stat(8'h00);
        // reset in mid-run with the latch set
        cmd(fsp_pkg::OP_WR_EN, 48'h0, 8, 1'b0);
        check(status_o, 8'h02);
        arst_n = 1'b0;
        repeat (5) @(negedge clock);
        arst_n = 1'b1;
        repeat (5) @(negedge clock);
        check(status_o, 8'h00);
        cmd(fsp_pkg::OP_RD_FLAG, 48'h0, 16, 1'b0);
        check(rd, 8'h81);
        summarize();
    end
endmodule
`default_nettype wire
